// ===== rtl/otpws_prog.sv
// Programmer that drives a one-time-programmable 16-bit memory through its pins
// Notes on behaviour
// [RULE1] Run starts at lowest word address
// [RULE2] Raise core and programming supplies first
// [RULE3] One 50 us pulse, no verify
// [RULE4] Verify loop per address after pulse
// [RULE5] Up to ten retry pulses, verify each
// [RULE6] Still failing after ten retries: device fails
// [RULE7] Verified word: step to next address
// [RULE8] Lower supplies, read back all, compare
// [RULE9] Pulse lasts 47.5 to 52.5 us
// [RULE10] Wait data valid and float delays
// [RULE11] Core supply on first, off last
// [RULE12] Identification: low line picks word, others low
// [RULE13] Identification: high voltage line, strobes low
// [RULE14] Retry counter per word, single pass flag
`timescale 1ns/1ps
`include "otpws_cfg.svh"
module otpws_prog
  import otpws_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     ce_i,
  input  wire logic                     start_i,
  input  wire logic                     id_start_i,
  input  wire logic                     id_sel_i,
  input  wire logic [`OTPWS_DATA_W-1:0] src_data_i,
  input  wire logic                     src_valid_i,
  output logic                          src_ready_o,
  output logic [`OTPWS_DATA_W-1:0]      rb_data_o,
  output logic                          rb_valid_o,
  input  wire logic                     rb_ready_i,
  output logic [`OTPWS_ADDR_W-1:0]      addr_o,
  output logic [`OTPWS_DATA_W-1:0]      data_out_o,
  output logic                          data_oe_o,
  input  wire logic [`OTPWS_DATA_W-1:0] data_in_i,
  output logic                          chip_sel_n_o,
  output logic                          out_drive_n_o,
  output logic                          program_strobe_n_o,
  output logic                          vcc_high_o,
  output logic                          vpp_high_o,
  output logic                          id_mode_line_o,
  output logic                          busy_o,
  output logic                          done_o,
  output logic                          pass_o,
  output logic [`OTPWS_DATA_W-1:0]      id_word_o
);
  localparam int DW = `OTPWS_DATA_W;
  localparam int AW = `OTPWS_ADDR_W;
  localparam int CW = 14;

  ////////////////////////////////////////////////////////////////////////////
  // State
  otpws_state_e      st_reg;
  logic [CW-1:0]     cnt_reg;
  logic [3:0]        retry_reg;
  logic              first_reg;
  logic [AW-1:0]     addr_reg;
  logic [DW-1:0]     word_reg;
  logic [DW-1:0]     dout_reg;
  logic              doe_reg;
  logic              cs_n_reg;
  logic              oe_n_reg;
  logic              pgm_n_reg;
  logic              vcc_reg;
  logic              vpp_reg;
  logic              idl_reg;
  logic              busy_reg;
  logic              done_reg;
  logic              pass_reg;
  logic              fail_reg;
  logic [DW-1:0]     id_reg;
  logic              rbv_reg;
  logic [DW-1:0]     rbd_reg;
  logic [DW-1:0]     fifo_data;
  logic              fifo_valid;
  logic              fifo_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Source words pass through an 8-word FIFO
  otpws_fifo #(
    .WIDTH (DW),
    .DEPTH (`OTPWS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_data_i   (src_data_i),
    .in_valid_i  (src_valid_i),
    .in_ready_o  (src_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  wire cnt_zero  = (cnt_reg == '0);
  wire last_addr = (addr_reg == `OTPWS_LAST_ADDR);
  wire match     = (data_in_i == word_reg);
  wire rb_free   = !rbv_reg || rb_ready_i;
  assign fifo_ready = ce_i && fifo_valid &&
                      ((st_reg == OTPWS_LOAD) || (st_reg == OTPWS_RB_DRV && cnt_zero && rb_free));

  localparam logic [CW-1:0] PULSE_C  = CW'(`OTPWS_PULSE_CYC - 1);   // [RULE9]
  localparam logic [CW-1:0] DVALID_C = CW'(`OTPWS_DVALID_CYC - 1);  // [RULE10]
  localparam logic [CW-1:0] FLOAT_C  = CW'(`OTPWS_FLOAT_CYC - 1);   // [RULE10]
  localparam logic [CW-1:0] SETUP_C  = CW'(`OTPWS_SETUP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg    <= OTPWS_IDLE;
      cnt_reg   <= '0;
      retry_reg <= '0;
      first_reg <= 1'b0;
      addr_reg  <= '0;
      word_reg  <= '0;
      dout_reg  <= '0;
      doe_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      pgm_n_reg <= 1'b1;
      vcc_reg   <= 1'b0;
      vpp_reg   <= 1'b0;
      idl_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      pass_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      id_reg    <= '0;
      rbv_reg   <= 1'b0;
      rbd_reg   <= '0;
    end else if (ce_i) begin
      if (rbv_reg && rb_ready_i) begin
        rbv_reg <= 1'b0;
      end
      if (!cnt_zero) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      case (st_reg)
        OTPWS_IDLE: begin
          if (start_i) begin
            addr_reg <= `OTPWS_FIRST_ADDR;                       // [RULE1]
            vcc_reg  <= 1'b1;                                    // [RULE11]
            cnt_reg  <= SETUP_C;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            pass_reg <= 1'b0;
            fail_reg <= 1'b0;
            st_reg   <= OTPWS_PWR_UP;
          end else if (id_start_i) begin
            addr_reg <= id_sel_i ? `OTPWS_ID_ADDR_PART : `OTPWS_ID_ADDR_MAKER; // [RULE12]
            idl_reg  <= 1'b1;                                    // [RULE13]
            cs_n_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            cnt_reg  <= DVALID_C;
            busy_reg <= 1'b1;
            st_reg   <= OTPWS_ID_DRV;
          end
        end
        OTPWS_PWR_UP: begin
          if (cnt_zero) begin
            if (!vpp_reg) begin
              vpp_reg <= 1'b1;                                   // [RULE2] [RULE11]
              cnt_reg <= SETUP_C;
            end else begin
              st_reg <= OTPWS_LOAD;
            end
          end
        end
        OTPWS_LOAD: begin
          if (fifo_valid) begin
            word_reg  <= fifo_data;
            dout_reg  <= fifo_data;
            doe_reg   <= 1'b1;
            retry_reg <= '0;                                     // [RULE14]
            first_reg <= 1'b1;
            cnt_reg   <= SETUP_C;
            st_reg    <= OTPWS_SETUP;
          end
        end
        OTPWS_SETUP: begin
          if (cnt_zero) begin
            cs_n_reg <= 1'b0;                                    // [RULE3] [RULE5]
            cnt_reg  <= PULSE_C;                                 // [RULE9]
            st_reg   <= OTPWS_PULSE;
          end
        end
        OTPWS_PULSE: begin
          if (cnt_zero) begin
            cs_n_reg <= 1'b1;
            cnt_reg  <= SETUP_C;
            st_reg   <= OTPWS_HOLD;
          end
        end
        OTPWS_HOLD: begin
          if (cnt_zero) begin
            doe_reg  <= 1'b0;
            cs_n_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            cnt_reg  <= DVALID_C;                                // [RULE10]
            st_reg   <= OTPWS_VFY_DRV;                           // [RULE4]
          end
        end
        OTPWS_VFY_DRV: begin
          if (cnt_zero) begin
            first_reg <= 1'b0;
            cs_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
            cnt_reg   <= FLOAT_C;                                // [RULE10]
            st_reg    <= OTPWS_VFY_FLT;
            // First pulse is never judged; its read only clears the bus
            if (!first_reg && match) begin
              st_reg <= OTPWS_NEXT;                              // [RULE7]
            end else if (!first_reg && retry_reg == `OTPWS_MAX_RETRY) begin
              st_reg <= OTPWS_PWR_DN;                            // [RULE6]
              fail_reg <= 1'b1;
            end
          end
        end
        OTPWS_VFY_FLT: begin
          if (cnt_zero) begin
            if (!first_reg) begin
              retry_reg <= retry_reg + 1'b1;                     // [RULE5] [RULE14]
            end
            doe_reg  <= 1'b1;
            cnt_reg  <= SETUP_C;
            st_reg   <= OTPWS_SETUP;
          end
        end
        OTPWS_NEXT: begin
          if (cnt_zero) begin
            if (last_addr) begin
              st_reg <= OTPWS_PWR_DN;
            end else begin
              addr_reg <= addr_reg + 1'b1;                       // [RULE7]
              st_reg   <= OTPWS_LOAD;
            end
          end
        end
        OTPWS_PWR_DN: begin
          if (cnt_zero) begin
            if (vpp_reg) begin
              vpp_reg <= 1'b0;                                   // [RULE8] [RULE11]
              cnt_reg <= SETUP_C;
            end else if (vcc_reg) begin
              vcc_reg <= 1'b0;
              cnt_reg <= SETUP_C;
            end else if (fail_reg) begin
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              st_reg   <= OTPWS_DONE;                            // [RULE6]
            end else begin
              addr_reg <= `OTPWS_FIRST_ADDR;
              pass_reg <= 1'b1;
              cs_n_reg <= 1'b0;
              oe_n_reg <= 1'b0;
              cnt_reg  <= DVALID_C;
              st_reg   <= OTPWS_RB_DRV;                          // [RULE8]
            end
          end
        end
        OTPWS_RB_DRV: begin
          if (cnt_zero && rb_free && fifo_valid) begin
            rbv_reg <= 1'b1;
            rbd_reg <= data_in_i;
            if (data_in_i != fifo_data) begin
              pass_reg <= 1'b0;                                  // [RULE8] [RULE14]
            end
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            cnt_reg  <= FLOAT_C;
            st_reg   <= OTPWS_RB_FLT;
          end
        end
        OTPWS_RB_FLT: begin
          if (cnt_zero) begin
            if (last_addr) begin
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              st_reg   <= OTPWS_DONE;
            end else begin
              addr_reg <= addr_reg + 1'b1;
              cs_n_reg <= 1'b0;
              oe_n_reg <= 1'b0;
              cnt_reg  <= DVALID_C;
              st_reg   <= OTPWS_RB_DRV;
            end
          end
        end
        OTPWS_ID_DRV: begin
          if (cnt_zero) begin
            id_reg   <= data_in_i;
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            cnt_reg  <= FLOAT_C;
            st_reg   <= OTPWS_ID_FLT;
          end
        end
        OTPWS_ID_FLT: begin
          if (cnt_zero) begin
            idl_reg  <= 1'b0;
            busy_reg <= 1'b0;
            st_reg   <= OTPWS_IDLE;
          end
        end
        OTPWS_DONE: begin
          if (start_i) begin
            st_reg <= OTPWS_IDLE;
          end
        end
        default: begin
          st_reg <= OTPWS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign addr_o             = addr_reg;
  assign data_out_o         = dout_reg;
  assign data_oe_o          = doe_reg;
  assign chip_sel_n_o       = cs_n_reg;
  assign out_drive_n_o      = oe_n_reg;
  assign program_strobe_n_o = pgm_n_reg;
  assign vcc_high_o         = vcc_reg;
  assign vpp_high_o         = vpp_reg;
  assign id_mode_line_o     = idl_reg;
  assign busy_o             = busy_reg;
  assign done_o             = done_reg;
  assign pass_o             = pass_reg;
  assign id_word_o          = id_reg;
  assign rb_data_o          = rbd_reg;
  assign rb_valid_o         = rbv_reg;
endmodule : otpws_prog

// ===== rtl/otpws_cfg.svh
// Constants for the one-time-programmable word programming sequencer
`ifndef OTPWS_CFG_SVH
`define OTPWS_CFG_SVH
`define OTPWS_CLK_MHZ       125
`define OTPWS_ADDR_W        17
`define OTPWS_DATA_W        16
`define OTPWS_LAST_ADDR     17'h1FFFF
`define OTPWS_FIRST_ADDR    17'h00000
`define OTPWS_MAX_RETRY     4'hA
// Pulse 50 us nominal, window 47.5 .. 52.5 us (values in ns)
`define OTPWS_PULSE_NS      50000
`define OTPWS_PULSE_CYC     ((`OTPWS_PULSE_NS * `OTPWS_CLK_MHZ) / 1000)
// Data valid after output drive, at most 150 ns; least wait rounds up
`define OTPWS_DVALID_NS     150
`define OTPWS_DVALID_CYC    ((`OTPWS_DVALID_NS * `OTPWS_CLK_MHZ + 999) / 1000)
// Float after output drive released, at most 130 ns
`define OTPWS_FLOAT_NS      130
`define OTPWS_FLOAT_CYC     ((`OTPWS_FLOAT_NS * `OTPWS_CLK_MHZ + 999) / 1000)
// Address, data and supply setup and hold, 2 us
`define OTPWS_SETUP_NS      2000
`define OTPWS_SETUP_CYC     ((`OTPWS_SETUP_NS * `OTPWS_CLK_MHZ + 999) / 1000)
`define OTPWS_ID_ADDR_MAKER 17'h00000
`define OTPWS_ID_ADDR_PART  17'h00001
`define OTPWS_FIFO_DEPTH    8
`endif

// ===== rtl/otpws_pkg.sv
// Types for the one-time-programmable word programming sequencer
package otpws_pkg;
  typedef enum {
    OTPWS_IDLE,
    OTPWS_PWR_UP,
    OTPWS_LOAD,
    OTPWS_SETUP,
    OTPWS_PULSE,
    OTPWS_HOLD,
    OTPWS_VFY_DRV,
    OTPWS_VFY_FLT,
    OTPWS_NEXT,
    OTPWS_PWR_DN,
    OTPWS_RB_DRV,
    OTPWS_RB_FLT,
    OTPWS_ID_DRV,
    OTPWS_ID_FLT,
    OTPWS_DONE
  } otpws_state_e;
endpackage : otpws_pkg

// ===== rtl/otpws_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module otpws_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             ready_reg;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = ready_reg;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end else if (ce_i) begin
      if (push) begin
        mem_reg[wr_reg] <= in_data_i;
        wr_reg          <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
        ready_reg <= (cnt_reg != (AW+1)'(DEPTH-1));
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
        ready_reg <= 1'b1;
      end
    end
  end
endmodule : otpws_fifo

// ===== testbench/otpws_prog_asserts.sv
// Concurrent checks on the programmer pins
`timescale 1ns/1ps
`include "otpws_cfg.svh"
module otpws_prog_asserts (
  input wire logic                     clk_i,
  input wire logic                     reset_i,
  input wire logic [`OTPWS_ADDR_W-1:0] addr_o,
  input wire logic                     data_oe_o,
  input wire logic                     chip_sel_n_o,
  input wire logic                     out_drive_n_o,
  input wire logic                     vcc_high_o,
  input wire logic                     vpp_high_o,
  input wire logic                     id_mode_line_o,
  input wire logic                     done_o
);
  logic [15:0]              low_cnt_reg;
  logic [15:0]              od_cnt_reg;
  logic [15:0]              flt_cnt_reg;
  logic [4:0]               pls_cnt_reg;
  logic [`OTPWS_ADDR_W-1:0] addr_prev_reg;
  wire                      pulse_start = !chip_sel_n_o && data_oe_o && low_cnt_reg == 16'h0000;

  // Cycle counters for strobe widths, float gaps and pulses per address
  always_ff @(posedge clk_i) begin
    low_cnt_reg   <= chip_sel_n_o ? 16'h0000 : low_cnt_reg + 16'h0001;
    od_cnt_reg    <= out_drive_n_o ? 16'h0000 : od_cnt_reg + 16'h0001;
    flt_cnt_reg   <= reset_i ? 16'h00FF : !out_drive_n_o ? 16'h0000 :
                     flt_cnt_reg + {15'h0000, flt_cnt_reg != 16'hFFFF};
    addr_prev_reg <= addr_o;
    pls_cnt_reg   <= (reset_i || addr_o != addr_prev_reg) ? 5'h00 :
                     pls_cnt_reg + {4'h0, pulse_start};
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_core_up;
    $rose(vcc_high_o) && !vpp_high_o;
  endsequence
  sequence s_prog_up;
    ##[250:260] $rose(vpp_high_o);
  endsequence

  a_power_up_order: assert property (s_core_up |-> s_prog_up)
    else $error("programming supply not raised 2 us after core supply");
  a_core_before_prog: assert property (vpp_high_o |-> vcc_high_o)
    else $error("programming supply high without core supply");
  a_supply_in_pulse: assert property (!chip_sel_n_o && data_oe_o |-> vcc_high_o && vpp_high_o)
    else $error("program pulse at nominal supplies");
  a_pulse_width_ok: assert property ($rose(chip_sel_n_o) && data_oe_o |->
    low_cnt_reg inside {[16'h1732:16'h19A2]})
    else $error("program pulse width out of window");
  a_verify_data_wait: assert property ($rose(out_drive_n_o) |-> od_cnt_reg >= 16'h0013)
    else $error("output drive released before data valid delay");
  a_verify_float_wait: assert property ($fell(out_drive_n_o) || $rose(data_oe_o) |->
    flt_cnt_reg >= 16'h0011)
    else $error("bus reused before float delay");
  a_no_bus_fight: assert property (!out_drive_n_o |-> !data_oe_o)
    else $error("data driven while memory drives");
  a_first_address: assert property ($rose(vcc_high_o) |-> addr_o == `OTPWS_FIRST_ADDR)
    else $error("run does not start at lowest address");
  a_retry_limit: assert property (pls_cnt_reg <= 5'h0B)
    else $error("more than ten retry pulses on one word");
  a_id_lines_held: assert property (id_mode_line_o && !out_drive_n_o |->
    !chip_sel_n_o && addr_o[16:1] == 16'h0000)
    else $error("identification address or strobes wrong");
  a_done_supplies_low: assert property (done_o |-> !vcc_high_o && !vpp_high_o)
    else $error("supplies high after run");
endmodule : otpws_prog_asserts

// ===== testbench/otpws_mem_model.sv
// Behavioural model of the one-time-programmable memory
`timescale 1ns/1ps
module otpws_mem_model #(
  parameter logic [15:0] ID_MAKER  = 16'h5A3C, // Arbitrary value
  parameter logic [15:0] ID_PART   = 16'hC3A5, // Arbitrary value
  parameter int          DVALID_NS = 150,
  parameter int          FLOAT_NS  = 130
) (
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        data_oe_i,
  input  wire logic        chip_sel_n_i,
  input  wire logic        out_drive_n_i,
  input  wire logic        vpp_high_i,
  input  wire logic        id_mode_line_i,
  input  wire logic        block_i,
  output logic      [15:0] data_o
);
  logic [15:0] mem [logic [16:0]];
  logic [15:0] last = 16'h0000;
  logic        drv  = 1'b0;

  function automatic logic [15:0] rd(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rd

  // Block input keeps cells erased so a word other than 16'hFFFF never verifies
  always @(posedge chip_sel_n_i)
    if (vpp_high_i && data_oe_i && !block_i) mem[addr_i] = rd(addr_i) & data_i;
  always @(negedge out_drive_n_i) drv <= #(DVALID_NS) 1'b1;
  always @(posedge out_drive_n_i) drv <= #(FLOAT_NS) 1'b0;
  always @(posedge drv)
    last = id_mode_line_i ? (addr_i[0] ? ID_PART : ID_MAKER) : rd(addr_i);
  // Released bus shows the inverse of the last word
  assign data_o = drv ? last : ~last;
endmodule : otpws_mem_model

// ===== testbench/otpws_prog_test.sv
// Self-checking bench for the word programming sequencer
`timescale 1ns/1ps
module otpws_prog_test;
  localparam logic [15:0] ID_MAKER = 16'h5A3C; // Arbitrary value
  localparam logic [15:0] ID_PART  = 16'hC3A5; // Arbitrary value
  logic        clk = 1'b0, reset = 1'b1, start = 1'b0, id_start = 1'b0, id_sel = 1'b0;
  logic        src_valid = 1'b0, block = 1'b0;
  logic [15:0] src_data = 16'h0000;
  logic [15:0] rb_data, data_out, data_in, id_word;
  logic [16:0] addr;
  logic        src_ready, rb_valid, data_oe, cs_n, od_n, pgm_n, vcc, vpp, idl, busy, done, pass_flag;
  int          fail_count = 0, n_tests = 0, n_pulse = 0;

  otpws_prog dut (
    .clk_i(clk), .reset_i(reset), .ce_i(1'b1), .start_i(start), .id_start_i(id_start),
    .id_sel_i(id_sel), .src_data_i(src_data), .src_valid_i(src_valid), .src_ready_o(src_ready),
    .rb_data_o(rb_data), .rb_valid_o(rb_valid), .rb_ready_i(1'b1), .addr_o(addr),
    .data_out_o(data_out), .data_oe_o(data_oe), .data_in_i(data_in), .chip_sel_n_o(cs_n),
    .out_drive_n_o(od_n), .program_strobe_n_o(pgm_n), .vcc_high_o(vcc), .vpp_high_o(vpp),
    .id_mode_line_o(idl), .busy_o(busy), .done_o(done), .pass_o(pass_flag), .id_word_o(id_word)
  );
  otpws_mem_model #(.ID_MAKER(ID_MAKER), .ID_PART(ID_PART)) u_mem (
    .addr_i(addr), .data_i(data_out), .data_oe_i(data_oe), .chip_sel_n_i(cs_n),
    .out_drive_n_i(od_n), .vpp_high_i(vpp), .id_mode_line_i(idl), .block_i(block),
    .data_o(data_in)
  );

  always #4 clk = ~clk;
  always @(posedge cs_n) if (data_oe === 1'b1) n_pulse++;

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(cs_n === 1'b1 && od_n === 1'b1 && pgm_n === 1'b1 && data_oe === 1'b0 && vcc === 1'b0
          && vpp === 1'b0 && busy === 1'b0 && done === 1'b0 && pass_flag === 1'b0, "reset");
  endtask : t_reset

  task automatic t_id(input logic sel, input logic [15:0] exp);
    int k;
    repeat (2) @(posedge clk);
    id_start <= 1'b1;
    id_sel   <= sel;
    @(posedge clk);
    id_start <= 1'b0;
    for (k = 0; k < 5 && idl !== 1'b1; k++) @(posedge clk);
    check(idl === 1'b1 && addr === {16'h0000, sel} && cs_n === 1'b0, "id select");
    for (k = 0; k < 60 && idl !== 1'b0; k++) @(posedge clk);
    check(id_word === exp && idl === 1'b0, "id word");
  endtask : t_id

  task automatic t_fill;
    int n;
    n = 0;
    src_valid <= 1'b1;
    src_data  <= 16'hA5C3;
    forever begin
      @(posedge clk);
      if (src_ready !== 1'b1 || n > 9) break;
      n++;
      src_data <= 16'hA5C3 + 16'(n);
    end
    src_valid <= 1'b0;
    check(n == 8, "fifo depth");
  endtask : t_fill

  task automatic t_fail_run;
    int k;
    block   <= 1'b1;
    n_pulse = 0;
    start   <= 1'b1;
    @(posedge clk);
    start   <= 1'b0;
    repeat (2) @(posedge clk);
    check(busy === 1'b1 && vcc === 1'b1 && vpp === 1'b0 && addr === 17'h00000, "power up");
    for (k = 0; k < 90000 && done !== 1'b1; k++) @(posedge clk);
    check(n_pulse == 11, "pulse count");
    check(done === 1'b1 && pass_flag === 1'b0 && busy === 1'b0, "fail flag");
    check(vcc === 1'b0 && vpp === 1'b0 && src_ready === 1'b1, "supplies off");
    check(rb_valid === 1'b0 && rb_data === 16'h0000, "no read-back after fail");
  endtask : t_fail_run

  task automatic t_restart;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    check(done === 1'b1 && busy === 1'b0 && vcc === 1'b0, "back to idle");
  endtask : t_restart

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_id(1'b0, ID_MAKER);
    t_id(1'b1, ID_PART);
    t_fill;
    t_fail_run;
    t_restart;
    t_id(1'b0, ID_MAKER);
    final_report;
  end

  // Failing run takes about 76k cycles; cut off at 100k
  initial begin
    #800000;
    fail_count++;
    final_report;
  end
endmodule : otpws_prog_test

bind otpws_prog otpws_prog_asserts u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_o(addr_o), .data_oe_o(data_oe_o),
  .chip_sel_n_o(chip_sel_n_o), .out_drive_n_o(out_drive_n_o), .vcc_high_o(vcc_high_o),
  .vpp_high_o(vpp_high_o), .id_mode_line_o(id_mode_line_o), .done_o(done_o)
);
